// >>> mgmt_pkg.sv
// Package of register offsets, field positions and reset values for the management bank
package mgmt_pkg;

  // ==========================================================
  // Register numbers
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_CONTROL_STATUS_INDICATION = 5'h1B;
  localparam logic [4:0] REG_INTERNAL_TEST_CONTROLS = 5'h1C;
  localparam logic [4:0] REG_INTERRUPT_SOURCE_FLAGS = 5'h1D;
  localparam logic [4:0] REG_INTERRUPT_MASK = 5'h1E;
  localparam logic [4:0] REG_SPECIAL_CONTROL_STATUS = 5'h1F;

  // ==========================================================
  // Basic control field positions
  localparam int CTL_SOFT_RESET = 15;
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;

  // ==========================================================
  // Basic status field positions and constant capability bits
  localparam int STS_AN_DONE = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  localparam logic [15:0] STS_CAPABILITY = 16'h7809;

  // ==========================================================
  // Vendor register fields
  localparam logic [15:0] IRQ_FLAG_MASK = 16'h00FE;
  localparam int SCS_AN_DONE = 12;
  localparam int SCS_GPO_LSB = 7;
  localparam int SCS_CODER = 6;
  localparam int SCS_SPEED_LSB = 2;
  localparam int SCS_SCRAMBLE_OFF = 0;
  localparam logic [15:0] SCS_WRITE_MASK = 16'h03C1;
  localparam logic [15:0] SCS_RESET = 16'h0040;
  localparam logic [15:0] CSI_RESET = 16'h0000;
  localparam logic [15:0] CSI_WRITE_MASK = 16'h3800;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // ==========================================================
  // Soft reset duration in management clocks
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;

  // Management access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  // Live line-side status inputs
  typedef struct packed {
    logic link_up;
    logic remote_fault;
    logic jabber;
    logic an_done;
    logic [2:0] speed_ind;
    logic [6:0] irq_events;
  } line_status_s;

endpackage

// >>> soft_reset_timer.sv
// Soft reset pulse stretcher for the management bank
`timescale 1ns/1ps
module soft_reset_timer
  import mgmt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  output logic busy_out
);

  // ==========================================================
  // Counter
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic busy_reg;
  logic busy_next;

  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    if (start_in) begin
      count_next = SOFT_RESET_CYCLES;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      count_next = count_reg - 4'h1;
      if (count_reg == 4'h1) begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_out = busy_reg;

endmodule

// >>> phy_management_register_bank.sv
// Management register bank: control, status and vendor registers
//
// Notes on behaviour
// RL1: Only listed register numbers respond; others unsupported.
// RL2: Soft reset bit self-clears when reset completes.
// RL3: Manager writes soft reset alone, others zero.
// RL4: Manual speed and duplex apply only without negotiation; the outputs carry the raw bits whatever an_enable_out is.
// RL5: Negotiation enable bit overrides manual speed, duplex; the bank does not gate speed_100_out or full_duplex_out by it.
// RL6: Restart negotiation bit self-clears after the restart.
// RL7: Power-down bit selects general power-down, resets zero.
// RL8: Isolate bit stops driving the media interface.
// RL9: Collision test bit; low seven bits read zero.
// RL10: Speed, negotiation, isolate, duplex reset from straps.
// RL11: Status capability bits read as fixed constants.
// RL12: Negotiation complete bit follows process completion.
// RL13: Remote fault and jabber latch high, clear on read.
// RL14: Link bit latches low until status read.
// RL15: Seven interrupt flags in 7:1, mask register matches.
// RL16: Special register fields: done, outputs, coder, speed.
// RL17: Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module phy_management_register_bank
  import mgmt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Serial management port access
  input wire mgmt_req_s req_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic supported_out,
  // Configuration straps
  input wire logic [2:0] mode_strap_in,
  // Line status
  input wire line_status_s line_in,
  // Controls to the transceiver
  output logic soft_reset_out,
  output logic an_enable_out,
  output logic an_restart_out,
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic power_down_out,
  output logic isolate_out,
  output logic col_test_out,
  output logic loopback_out,
  output logic [2:0] general_output_bit_out,
  output logic block_coder_enable_out,
  output logic scramble_disable_out,
  output logic [6:0] irq_mask_out
);

  // ==========================================================
  // State
  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic strap_load_reg;
  logic strap_load_next;
  logic fault_reg, fault_next;
  logic jabber_reg, jabber_next;
  logic link_reg, link_next;
  logic [15:0] csi_reg, csi_next;
  logic [6:0] flags_reg, flags_next;
  logic [6:0] mask_reg, mask_next;
  logic [15:0] scs_reg, scs_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic supported_reg, supported_next;
  logic restart_pulse_reg, restart_pulse_next;
  logic sr_busy;
  logic sr_start;
  logic sr_busy_d_reg;
  logic sr_done;

  // Supported register numbers
  function automatic logic is_supported(input logic [4:0] a);
    is_supported = (a <= 5'h06) || (a >= 5'h10 && a <= 5'h12) ||
                   (a >= 5'h14 && a <= 5'h17) || (a >= 5'h1B); // [RL1]
  endfunction

  // Strap-derived control defaults
  function automatic logic [15:0] strap_ctl(input logic [2:0] m);
    logic [15:0] v;
    v = 16'h0000;
    v[CTL_SPEED] = m[0];
    v[CTL_DUPLEX] = m[1];
    v[CTL_AN_ENABLE] = m[2];
    v[CTL_ISOLATE] = (m == 3'h0);
    strap_ctl = v; // [RL10]
  endfunction

  soft_reset_timer u_soft_reset_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(sr_start),
    .busy_out(sr_busy)
  );

  wire logic wr_ctl = req_in.wr && req_in.addr == REG_BASIC_CONTROL;
  wire logic rd_sts = req_in.rd && req_in.addr == REG_BASIC_STATUS;
  wire logic rd_flags = req_in.rd && req_in.addr == REG_INTERRUPT_SOURCE_FLAGS;
  // Manager is expected to write the reset bit alone [RL3]
  // Writes dropped until bit 15 clears, reload edge included
  assign sr_start = wr_ctl && req_in.wdata[CTL_SOFT_RESET] && !ctl_reg[CTL_SOFT_RESET]; // [RL2]
  assign sr_done = sr_busy_d_reg && !sr_busy;

  // ==========================================================
  // Next-state logic
  always_comb begin
    ctl_next = ctl_reg;
    strap_load_next = 1'b0;
    fault_next = fault_reg | line_in.remote_fault;
    jabber_next = jabber_reg | line_in.jabber;
    link_next = link_reg & line_in.link_up;
    csi_next = csi_reg;
    flags_next = flags_reg;
    mask_next = mask_reg;
    scs_next = scs_reg;
    restart_pulse_next = 1'b0;
    rvalid_next = req_in.rd;
    supported_next = is_supported(req_in.addr); // [RL1]
    rdata_next = 16'h0000;
    // Straps caught after reset release, not under it
    if (strap_load_reg) begin
      ctl_next = strap_ctl(mode_strap_in); // [RL10]
    end
    // Clear on read; a new event in the same cycle wins
    if (rd_sts) begin
      fault_next = line_in.remote_fault; // [RL13]
      jabber_next = line_in.jabber; // [RL13]
      link_next = line_in.link_up; // [RL14]
    end
    flags_next = (rd_flags ? 7'h00 : flags_reg) | line_in.irq_events; // [RL15]
    if (wr_ctl && !ctl_reg[CTL_SOFT_RESET]) begin
      ctl_next = req_in.wdata & 16'hFF80; // [RL9] [RL17]
      if (req_in.wdata[CTL_AN_RESTART]) begin
        restart_pulse_next = 1'b1; // [RL6]
      end
      ctl_next[CTL_AN_RESTART] = 1'b0; // [RL6]
    end
    if (req_in.wr && !ctl_reg[CTL_SOFT_RESET]) begin
      unique case (req_in.addr)
        REG_CONTROL_STATUS_INDICATION: csi_next = req_in.wdata & CSI_WRITE_MASK; // [RL17]
        REG_INTERRUPT_MASK: mask_next = req_in.wdata[7:1]; // [RL15]
        REG_SPECIAL_CONTROL_STATUS: scs_next = req_in.wdata & SCS_WRITE_MASK; // [RL16] [RL17]
        default: begin
        end
      endcase
    end
    // Soft reset returns control, CSI, mask and special registers to defaults; bit clears at the end
    if (sr_done) begin
      ctl_next = strap_ctl(mode_strap_in); // [RL2]
      csi_next = CSI_RESET;
      mask_next = MASK_RESET[7:1];
      scs_next = SCS_RESET;
    end
    if (sr_busy) begin
      ctl_next[CTL_SOFT_RESET] = 1'b1; // [RL2]
    end
    if (req_in.rd) begin
      unique case (req_in.addr)
        REG_BASIC_CONTROL: rdata_next = ctl_reg & 16'hFF80; // [RL9]
        REG_BASIC_STATUS: begin
          rdata_next = STS_CAPABILITY; // [RL11]
          rdata_next[STS_AN_DONE] = line_in.an_done; // [RL12]
          rdata_next[STS_REMOTE_FAULT] = fault_reg; // [RL13]
          rdata_next[STS_JABBER] = jabber_reg; // [RL13]
          rdata_next[STS_LINK] = link_reg; // [RL14]
        end
        REG_CONTROL_STATUS_INDICATION: rdata_next = csi_reg;
        REG_INTERRUPT_SOURCE_FLAGS: rdata_next = {8'h00, flags_reg, 1'b0}; // [RL15]
        REG_INTERRUPT_MASK: rdata_next = {8'h00, mask_reg, 1'b0}; // [RL15]
        REG_SPECIAL_CONTROL_STATUS: begin
          rdata_next = scs_reg; // [RL16]
          rdata_next[SCS_AN_DONE] = line_in.an_done; // [RL16]
          rdata_next[SCS_SPEED_LSB +: 3] = line_in.speed_ind; // [RL16]
        end
        // Unsupported and unmodelled registers read zero
        default: rdata_next = 16'h0000; // [RL17]
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_reg <= 16'h0000;
      strap_load_reg <= 1'b1;
      fault_reg <= 1'b0;
      jabber_reg <= 1'b0;
      link_reg <= 1'b0;
      csi_reg <= CSI_RESET;
      flags_reg <= 7'h00;
      mask_reg <= MASK_RESET[7:1];
      scs_reg <= SCS_RESET;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      supported_reg <= 1'b0;
      restart_pulse_reg <= 1'b0;
      sr_busy_d_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      strap_load_reg <= strap_load_next;
      fault_reg <= fault_next;
      jabber_reg <= jabber_next;
      link_reg <= link_next;
      csi_reg <= csi_next;
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      scs_reg <= scs_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      supported_reg <= supported_next;
      restart_pulse_reg <= restart_pulse_next;
      sr_busy_d_reg <= sr_busy;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign supported_out = supported_reg;
  assign soft_reset_out = ctl_reg[CTL_SOFT_RESET];
  assign an_enable_out = ctl_reg[CTL_AN_ENABLE]; // [RL5]
  assign an_restart_out = restart_pulse_reg; // [RL6]
  // Raw manual bits; the consumer ignores them while negotiation runs
  assign speed_100_out = ctl_reg[CTL_SPEED]; // [RL4]
  assign full_duplex_out = ctl_reg[CTL_DUPLEX]; // [RL4]
  assign power_down_out = ctl_reg[CTL_POWER_DOWN]; // [RL7]
  assign isolate_out = ctl_reg[CTL_ISOLATE]; // [RL8]
  assign col_test_out = ctl_reg[CTL_COL_TEST]; // [RL9]
  assign loopback_out = ctl_reg[CTL_LOOPBACK];
  assign general_output_bit_out = scs_reg[SCS_GPO_LSB +: 3]; // [RL16]
  assign block_coder_enable_out = scs_reg[SCS_CODER]; // [RL16]
  assign scramble_disable_out = scs_reg[SCS_SCRAMBLE_OFF]; // [RL16]
  assign irq_mask_out = mask_reg;

endmodule

// >>> phy_mgmt_assertions.sv
// Concurrent checks on the management bank ports
`timescale 1ns/1ps
module phy_mgmt_assertions
  import mgmt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire mgmt_req_s req_in,
  input wire line_status_s line_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic supported_out,
  input wire logic soft_reset_out,
  input wire logic an_restart_out,
  input wire logic an_enable_out,
  input wire logic speed_100_out,
  input wire logic full_duplex_out,
  input wire logic power_down_out,
  input wire logic isolate_out,
  input wire logic col_test_out,
  input wire logic [6:0] irq_mask_out
);
  // ==========================================
  // Clocking
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  logic ctl_wr;
  // Writes during soft reset are dropped, so they are left out
  assign ctl_wr = req_in.wr && req_in.addr == REG_BASIC_CONTROL && !soft_reset_out;
  // ==========================================
  // Checks
  chk_read_answer: assert property (req_in.rd |=> rvalid_out)
    else $error("read not answered next cycle");
  chk_unsup_zero: assert property (rvalid_out && !supported_out |-> rdata_out == 16'h0000)
    else $error("unsupported read not zero");
  chk_ctl_low_zero: assert property (rvalid_out && $past(req_in.addr) == REG_BASIC_CONTROL |-> rdata_out[6:0] == 7'h00)
    else $error("control low bits not zero");
  chk_status_caps: assert property (rvalid_out && $past(req_in.addr) == REG_BASIC_STATUS |-> (rdata_out & 16'hFFC9) == STS_CAPABILITY)
    else $error("status constant bits wrong");
  chk_fault_latch: assert property (line_in.remote_fault ##1 !(req_in.rd && req_in.addr == REG_BASIC_STATUS) ##1 (req_in.rd && req_in.addr == REG_BASIC_STATUS) |=> rdata_out[STS_REMOTE_FAULT])
    else $error("remote fault not latched");
  chk_jabber_latch: assert property (line_in.jabber ##1 !(req_in.rd && req_in.addr == REG_BASIC_STATUS) ##1 (req_in.rd && req_in.addr == REG_BASIC_STATUS) |=> rdata_out[STS_JABBER])
    else $error("jabber not latched");
  chk_soft_start: assert property (ctl_wr && req_in.wdata[CTL_SOFT_RESET] |=> soft_reset_out)
    else $error("soft reset did not start");
  chk_soft_clear: assert property ($rose(soft_reset_out) |-> soft_reset_out[*8] ##[1:2] !soft_reset_out)
    else $error("soft reset length wrong");
  chk_restart_pulse: assert property (ctl_wr && req_in.wdata[CTL_AN_RESTART] && !req_in.wdata[CTL_SOFT_RESET] |=> an_restart_out ##1 !an_restart_out)
    else $error("restart pulse wrong");
  chk_ctl_write: assert property (ctl_wr && !req_in.wdata[CTL_SOFT_RESET] |=> {speed_100_out, an_enable_out, power_down_out, isolate_out, full_duplex_out, col_test_out} == {$past(req_in.wdata[13:10]), $past(req_in.wdata[8:7])})
    else $error("control outputs do not follow write");
  chk_mask_write: assert property (req_in.wr && req_in.addr == REG_INTERRUPT_MASK && !soft_reset_out |=> irq_mask_out == $past(req_in.wdata[7:1]))
    else $error("mask output does not follow write");
endmodule

bind phy_management_register_bank phy_mgmt_assertions u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req_in),
  .line_in(line_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .supported_out(supported_out),
  .soft_reset_out(soft_reset_out), .an_restart_out(an_restart_out), .an_enable_out(an_enable_out),
  .speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out), .power_down_out(power_down_out),
  .isolate_out(isolate_out), .col_test_out(col_test_out), .irq_mask_out(irq_mask_out));

// >>> mgmt_station_model.sv
// Station manager model issuing management requests
`timescale 1ns/1ps
module mgmt_station_model
  import mgmt_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Requests
  output mgmt_req_s req_out
);
  // ==========================================
  // Bus cycle
  initial req_out = '0;
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk_in);
    // Idle fields inverted so a stale address never passes for a live one
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic soft_reset();
    xfer(1'b1, REG_BASIC_CONTROL, 16'h8000);
  endtask
endmodule

// >>> tb_phy_management_register_bank.sv
// Self-checking testbench for the management register bank
`timescale 1ns/1ps
module tb_phy_management_register_bank;
  import mgmt_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] mode_strap_in;
  line_status_s line_in;
  mgmt_req_s req;
  logic [15:0] rdata_out;
  logic rvalid_out;
  logic supported_out;
  logic soft_reset_out;
  logic loopback_out, speed_100_out, an_enable_out, power_down_out, isolate_out, full_duplex_out, col_test_out;
  logic [2:0] general_output_bit_out;
  logic block_coder_enable_out, scramble_disable_out;
  wire logic [15:0] ctl_out = {9'h000, loopback_out, speed_100_out, an_enable_out, power_down_out, isolate_out,
    full_duplex_out, col_test_out};
  wire logic [15:0] scs_out = {6'h00, general_output_bit_out, block_coder_enable_out, 5'h00, scramble_disable_out};
  logic [32:0] q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  logic [15:0] w;
  int i;
  // ==========================================
  // Design and partner
  phy_management_register_bank dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .supported_out(supported_out), .mode_strap_in(mode_strap_in), .line_in(line_in),
    .soft_reset_out(soft_reset_out), .an_enable_out(an_enable_out), .an_restart_out(),
    .speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out), .power_down_out(power_down_out),
    .isolate_out(isolate_out), .col_test_out(col_test_out), .loopback_out(loopback_out),
    .general_output_bit_out(general_output_bit_out), .block_coder_enable_out(block_coder_enable_out),
    .scramble_disable_out(scramble_disable_out), .irq_mask_out());
  mgmt_station_model u_sta (.ref_clk_in(ref_clk_in), .req_out(req));
  initial forever #50 ref_clk_in = ~ref_clk_in;
  // ==========================================
  // Tasks
  task automatic fail(input string s);
    n_mismatch++;
    $display("FAIL %0t %s", $time, s);
  endtask
  task automatic cmp_data(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("read %h expected %h", g, e));
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    checks_done++;
    if (g !== e) fail("supported flag wrong");
  endtask
  function automatic logic sup(input logic [4:0] a);
    return a <= 5'h06 || (a >= 5'h10 && a != 5'h13 && a <= 5'h17) || a >= 5'h1B;
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_sta.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    q.push_back({sup(a), m, e});
    u_sta.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic pulse(input line_status_s v);
    line_status_s keep;
    keep = line_in;
    @(negedge ref_clk_in);
    line_in <= v;
    @(negedge ref_clk_in);
    line_in <= keep;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Monitor
  always @(negedge ref_clk_in) begin
    if (rvalid_out === 1'b1) begin
      if (q.size() == 0) fail("unexpected read answer");
      else begin
        cmp_data(rdata_out & q[0][31:16], q[0][15:0]);
        cmp_flag(supported_out, q[0][32]);
        void'(q.pop_front());
      end
    end
  end
  initial begin
    #(100 * 5000);
    fail("timeout");
    finish_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    line_status_s lv;
    void'($urandom(32'h5439B24E));
    mode_strap_in = 3'($urandom);
    line_in = '{link_up: 1'b1, remote_fault: 1'b0, jabber: 1'b0, an_done: 1'b1, speed_ind: 3'($urandom), irq_events: 7'h00};
    repeat (3) @(negedge ref_clk_in);
    rst_in = 1'b0;
    rd(REG_BASIC_CONTROL, {2'b00, mode_strap_in[0], mode_strap_in[2], 1'b0, mode_strap_in == 3'b000, 1'b0,
      mode_strap_in[1], 8'h00}, 16'hFFFF);
    rd(REG_SPECIAL_CONTROL_STATUS, SCS_RESET | 16'h1000 | {11'h000, line_in.speed_ind, 2'b00}, 16'hFFFF);
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0020, 16'hFFFB);
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0024, 16'hFFFF);
    cmp_data(scs_out, SCS_RESET);
    $display("test reset_values done");
    for (i = 0; i < 4; i++) begin
      w = 16'($urandom) & 16'h7DFF;
      wr(REG_BASIC_CONTROL, w);
      cmp_data(ctl_out, {9'h000, w[14:10], w[8:7]});
      rd(REG_BASIC_CONTROL, w & 16'h7D80, 16'hFFFF);
    end
    wr(REG_BASIC_CONTROL, 16'h1200);
    rd(REG_BASIC_CONTROL, 16'h1000, 16'hFFFF);
    $display("test control done");
    // Straps changed so the reload is visible
    mode_strap_in = 3'b000;
    u_sta.soft_reset();
    wr(REG_BASIC_CONTROL, 16'h2000);
    i = 0;
    while (soft_reset_out !== 1'b0 && i < 20) begin
      @(negedge ref_clk_in);
      i++;
    end
    if (i == 20) begin
      fail("soft reset stuck");
      finish_test();
    end
    rd(REG_BASIC_CONTROL, 16'h0400, 16'hFFFF);
    $display("test soft_reset done");
    lv = line_in;
    lv.jabber = 1'b1;
    lv.remote_fault = 1'b1;
    pulse(lv);
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0036, 16'hFFFF);
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0024, 16'hFFFF);
    lv = line_in;
    lv.link_up = 1'b0;
    pulse(lv);
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0020, 16'hFFFF);
    line_in.an_done = 1'b0;
    rd(REG_BASIC_STATUS, STS_CAPABILITY | 16'h0004, 16'hFFFF);
    $display("test status done");
    w = 16'($urandom);
    wr(REG_INTERRUPT_MASK, w);
    rd(REG_INTERRUPT_MASK, w & IRQ_FLAG_MASK, 16'hFFFF);
    lv = line_in;
    lv.irq_events = 7'h55;
    pulse(lv);
    rd(REG_INTERRUPT_SOURCE_FLAGS, 16'h00AA, 16'hFFFF);
    rd(REG_INTERRUPT_SOURCE_FLAGS, 16'h0000, 16'hFFFF);
    wr(REG_SPECIAL_CONTROL_STATUS, w);
    cmp_data(scs_out, w & SCS_WRITE_MASK);
    rd(REG_SPECIAL_CONTROL_STATUS, (w & SCS_WRITE_MASK) | {11'h000, line_in.speed_ind, 2'b00}, 16'hFFFF);
    wr(REG_CONTROL_STATUS_INDICATION, w);
    rd(REG_CONTROL_STATUS_INDICATION, w & CSI_WRITE_MASK, 16'hFFFF);
    $display("test vendor done");
    for (i = 2; i < 27; i++) begin
      wr(5'(i), 16'($urandom));
      rd(5'(i), 16'h0000, 16'hFFFF);
    end
    $display("test unsupported done");
    i = 0;
    while (q.size() != 0 && i < 10) begin
      @(negedge ref_clk_in);
      i++;
    end
    if (i == 10) fail("answers missing");
    finish_test();
  end
endmodule
